// file: shared/cpr_pkg.sv
/*
 * constants, field layouts and carrier types of the converter program registers.
 * assumes one clock domain shared with the serial port engine that feeds the register port.
 */
package cpr_pkg;

	// ==========================================================
	// widths
	localparam int CPR_DATA_W = 14;
	localparam int CPR_REG_W = 8;

	// ==========================================================
	// register offsets
	localparam logic [7:0] CPR_ADDR_MODES = 8'h08;
	localparam logic [7:0] CPR_ADDR_CLK_DIV = 8'h0B;
	localparam logic [7:0] CPR_ADDR_TEST = 8'h0D;
	localparam logic [7:0] CPR_ADDR_SELF_TEST = 8'h0E;
	localparam logic [7:0] CPR_ADDR_OFFSET = 8'h10;
	localparam logic [7:0] CPR_ADDR_COMMIT = 8'hFF;

	// ==========================================================
	// reset values
	localparam logic [7:0] CPR_RST_MODES = 8'h00;
	localparam logic [7:0] CPR_RST_CLK_DIV = 8'h00;
	localparam logic [7:0] CPR_RST_TEST = 8'h00;
	localparam logic [7:0] CPR_RST_SELF_TEST = 8'h00;
	localparam logic [7:0] CPR_RST_OFFSET = 8'h00;

	// ==========================================================
	// field positions
	localparam int CPR_COMMIT_BIT = 0;
	localparam int CPR_PIN_EN_BIT = 7;
	localparam int CPR_PIN_FN_LSB = 5;
	localparam int CPR_PWR_LSB = 0;
	localparam int CPR_DIV_LSB = 0;
	localparam int CPR_TEST_LSB = 0;
	localparam int CPR_RST_SHORT_BIT = 4;
	localparam int CPR_RST_LONG_BIT = 5;
	localparam int CPR_ST_RUN_BIT = 0;
	localparam int CPR_ST_INIT_BIT = 2;

	// ==========================================================
	// field masks of writable bits
	localparam logic [7:0] CPR_MASK_MODES = 8'hE3;
	localparam logic [7:0] CPR_MASK_CLK_DIV = 8'h07;
	localparam logic [7:0] CPR_MASK_TEST = 8'hFF;
	localparam logic [7:0] CPR_MASK_SELF_TEST = 8'h05;
	localparam logic [7:0] CPR_MASK_OFFSET = 8'hFF;

	// ==========================================================
	// mode pin functions and power modes
	localparam logic [1:0] CPR_PIN_PWR_DOWN = 2'h0;
	localparam logic [1:0] CPR_PIN_STANDBY = 2'h1;
	localparam logic [1:0] CPR_PIN_NORM_OFF = 2'h2;
	localparam logic [1:0] CPR_PIN_NORM_ON = 2'h3;
	localparam logic [1:0] CPR_PWR_RUN = 2'h0;
	localparam logic [1:0] CPR_PWR_DOWN = 2'h1;
	localparam logic [1:0] CPR_PWR_STANDBY = 2'h2;
	localparam logic [1:0] CPR_PWR_RESET = 2'h3;

	// ==========================================================
	// output test codes
	localparam logic [3:0] CPR_TP_OFF = 4'h0;
	localparam logic [3:0] CPR_TP_MID = 4'h1;
	localparam logic [3:0] CPR_TP_POS_FS = 4'h2;
	localparam logic [3:0] CPR_TP_NEG_FS = 4'h3;
	localparam logic [3:0] CPR_TP_CHECKER = 4'h4;
	localparam logic [3:0] CPR_TP_LONG_PRS = 4'h5;
	localparam logic [3:0] CPR_TP_SHORT_PRS = 4'h6;
	localparam logic [3:0] CPR_TP_WORD_TGL = 4'h7;
	localparam logic [3:0] CPR_TP_USER = 4'h8;
	localparam logic [3:0] CPR_TP_BIT_TGL = 4'h9;
	localparam logic [3:0] CPR_TP_SYNC = 4'hA;
	localparam logic [3:0] CPR_TP_ONE_HIGH = 4'hB;
	localparam logic [3:0] CPR_TP_MIXED = 4'hC;

	// ==========================================================
	// pseudo-random generators
	localparam int CPR_LONG_LEN = 23;
	localparam int CPR_LONG_TAP = 17;
	localparam int CPR_SHORT_LEN = 9;
	localparam int CPR_SHORT_TAP = 4;
	localparam logic [22:0] CPR_LONG_SEED = 23'h7FFFFF;
	localparam logic [8:0] CPR_SHORT_SEED = 9'h1FF;
	localparam int CPR_MIX_W = 4;

	// ==========================================================
	// carriers
	typedef struct packed {
		logic wr_en;
		logic rd_en;
		logic [7:0] addr;
		logic [7:0] wdata;
	} cpr_req_s;

	typedef struct packed {
		logic [7:0] modes;
		logic [7:0] clk_div;
		logic [7:0] test;
		logic [7:0] self_test;
		logic [7:0] offset;
	} cpr_cfg_s;

endpackage

// file: rtl/cpr_pattern_gen.sv
/*
 * output test word generator: fixed words, toggles and pseudo-random sequences.
 * assumes advance pulses once per converter sample, on the same clock.
 */
`timescale 1ns/1ps
module cpr_pattern_gen #(
	parameter int DATA_W = cpr_pkg::CPR_DATA_W
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic advance,
	input wire logic [3:0] test_code,
	input wire logic reset_long,
	input wire logic reset_short,
	input wire logic [DATA_W-1:0] user_pattern,
	output logic [DATA_W-1:0] pattern
);
	import cpr_pkg::*;

	// ==========================================================
	// generator state
	logic [CPR_LONG_LEN-1:0] long_q, long_d;
	logic [CPR_SHORT_LEN-1:0] short_q, short_d;
	logic [CPR_MIX_W-1:0] mix_q, mix_d;
	logic phase_q, phase_d;
	logic [DATA_W-1:0] pattern_q, pattern_d;
	logic [DATA_W-1:0] long_w, short_w, mix_w, checker_w;

	// ==========================================================
	// per-bit words
	genvar i;
	generate
		for (i = 0; i < DATA_W; i++) begin : g_bits
			assign long_w[i] = long_q[i % CPR_LONG_LEN];
			assign short_w[i] = short_q[i % CPR_SHORT_LEN];
			assign mix_w[i] = mix_q[i % CPR_MIX_W];
			assign checker_w[i] = ((i % 2) == 1) ^ phase_q;
		end
	endgenerate

	always_comb begin
		long_d = long_q;
		short_d = short_q;
		mix_d = mix_q;
		phase_d = phase_q;
		pattern_d = pattern_q;
		if (reset_long) begin
			long_d = CPR_LONG_SEED;
		end else if (advance) begin
			long_d = {long_q[CPR_LONG_LEN-2:0], long_q[CPR_LONG_LEN-1] ^ long_q[CPR_LONG_TAP]};
		end
		if (reset_short) begin
			short_d = CPR_SHORT_SEED;
		end else if (advance) begin
			short_d = {short_q[CPR_SHORT_LEN-2:0],
				short_q[CPR_SHORT_LEN-1] ^ short_q[CPR_SHORT_TAP]};
		end
		if (advance) begin
			mix_d = mix_q + 1'b1;
			phase_d = ~phase_q;
			case (test_code)
				CPR_TP_MID: pattern_d = '0;
				CPR_TP_POS_FS: pattern_d = {1'b0, {(DATA_W-1){1'b1}}};
				CPR_TP_NEG_FS: pattern_d = {1'b1, {(DATA_W-1){1'b0}}};
				CPR_TP_CHECKER: pattern_d = checker_w;
				CPR_TP_LONG_PRS: pattern_d = long_w;
				CPR_TP_SHORT_PRS: pattern_d = short_w;
				CPR_TP_WORD_TGL: pattern_d = {DATA_W{phase_q}};
				CPR_TP_USER: pattern_d = user_pattern;
				CPR_TP_BIT_TGL: pattern_d = {{(DATA_W-1){1'b0}}, phase_q};
				CPR_TP_SYNC: pattern_d = {{(DATA_W/2){1'b1}}, {(DATA_W-DATA_W/2){1'b0}}};
				CPR_TP_ONE_HIGH: pattern_d = {{(DATA_W-1){1'b0}}, 1'b1};
				CPR_TP_MIXED: pattern_d = mix_w;
				default: pattern_d = '0;
			endcase
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			long_q <= CPR_LONG_SEED;
			short_q <= CPR_SHORT_SEED;
			mix_q <= '0;
			phase_q <= 1'b0;
			pattern_q <= '0;
		end else begin
			long_q <= long_d;
			short_q <= short_d;
			mix_q <= mix_d;
			phase_q <= phase_d;
			pattern_q <= pattern_d;
		end
	end

	assign pattern = pattern_q;

endmodule

// file: rtl/cpr_top.sv
/*
 * converter program registers: shadowed configuration, commit, mode pin, clock divider,
 * test pattern selection, self-test control and offset trim on the sample path.
 * assumes the serial port engine delivers decoded byte writes and reads on clk,
 * and that sample_in is a two's-complement conversion result on the same clock.
 */
// Overview of operation
// - a write with bit 0 set to the commit register copies every shadow into the active set at once.
// - writes to the program registers change only the shadows until a commit happens.
// - the host commits by writing 0x01 and the commit bit clears itself after the update.
// - the mode pin function field picks power-down, standby, outputs off or outputs on.
// - the mode pin acts only while its enable bit is set, otherwise it is ignored.
// - the input clock is divided by the divider field plus one.
// - a nonzero test code puts the test word on the data outputs instead of samples.
// - codes 0 to 3 give normal data, midscale, positive and negative full scale.
// - codes 4, 7 and 9 give checkerboard, word toggle and bit toggle.
// - codes 5 and 6 give the long and short pseudo-random sequences.
// - codes 8, 10, 11 and 12 give user, sync, one-bit-high and mixed-frequency words.
// - the offset trim is a signed byte added to each sample with saturation.
`timescale 1ns/1ps
module cpr_top #(
	parameter int DATA_W = cpr_pkg::CPR_DATA_W
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire cpr_pkg::cpr_req_s reg_req,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic mode_pin,
	input wire logic [DATA_W-1:0] sample_in,
	input wire logic [DATA_W-1:0] user_pattern,
	output logic [DATA_W-1:0] data_out,
	output logic sample_strobe,
	output logic out_enable,
	output logic power_down,
	output logic standby,
	output logic digital_reset,
	output logic self_test_run,
	output logic self_test_init
);
	import cpr_pkg::*;

	// ==========================================================
	// shadow and active registers
	cpr_cfg_s shadow_q, shadow_d;
	cpr_cfg_s active_q, active_d;
	logic commit_q, commit_d;
	logic [7:0] rdata_q, rdata_d;
	logic rvalid_q, rvalid_d;

	always_comb begin
		shadow_d = shadow_q;
		active_d = active_q;
		commit_d = 1'b0;
		rdata_d = rdata_q;
		rvalid_d = reg_req.rd_en;
		if (commit_q) begin
			active_d = shadow_q;
		end
		if (reg_req.wr_en) begin
			case (reg_req.addr)
				CPR_ADDR_MODES: shadow_d.modes = reg_req.wdata & CPR_MASK_MODES;
				CPR_ADDR_CLK_DIV: shadow_d.clk_div = reg_req.wdata & CPR_MASK_CLK_DIV;
				CPR_ADDR_TEST: shadow_d.test = reg_req.wdata & CPR_MASK_TEST;
				CPR_ADDR_SELF_TEST: shadow_d.self_test = reg_req.wdata & CPR_MASK_SELF_TEST;
				CPR_ADDR_OFFSET: shadow_d.offset = reg_req.wdata & CPR_MASK_OFFSET;
				CPR_ADDR_COMMIT: commit_d = reg_req.wdata[CPR_COMMIT_BIT];
				default: commit_d = 1'b0;
			endcase
		end
		if (reg_req.rd_en) begin
			case (reg_req.addr)
				CPR_ADDR_MODES: rdata_d = shadow_q.modes;
				CPR_ADDR_CLK_DIV: rdata_d = shadow_q.clk_div;
				CPR_ADDR_TEST: rdata_d = shadow_q.test;
				CPR_ADDR_SELF_TEST: rdata_d = shadow_q.self_test;
				CPR_ADDR_OFFSET: rdata_d = shadow_q.offset;
				CPR_ADDR_COMMIT: rdata_d = {7'h00, commit_q};
				default: rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			shadow_q <= {CPR_RST_MODES, CPR_RST_CLK_DIV, CPR_RST_TEST, CPR_RST_SELF_TEST,
				CPR_RST_OFFSET};
			active_q <= {CPR_RST_MODES, CPR_RST_CLK_DIV, CPR_RST_TEST, CPR_RST_SELF_TEST,
				CPR_RST_OFFSET};
			commit_q <= 1'b0;
			rdata_q <= 8'h00;
			rvalid_q <= 1'b0;
		end else begin
			shadow_q <= shadow_d;
			active_q <= active_d;
			commit_q <= commit_d;
			rdata_q <= rdata_d;
			rvalid_q <= rvalid_d;
		end
	end

	assign reg_rdata = rdata_q;
	assign reg_rvalid = rvalid_q;

	// ==========================================================
	// mode pin synchroniser and power state
	logic pin_s1_q, pin_s2_q;
	logic pwr_down_q, pwr_down_d;
	logic standby_q, standby_d;
	logic oe_q, oe_d;
	logic dreset_q, dreset_d;
	logic [1:0] pin_fn;
	logic [1:0] pwr_mode;

	assign pin_fn = active_q.modes[CPR_PIN_FN_LSB +: 2];
	assign pwr_mode = active_q.modes[CPR_PWR_LSB +: 2];

	always_comb begin
		pwr_down_d = 1'b0;
		standby_d = 1'b0;
		oe_d = 1'b1;
		dreset_d = 1'b0;
		case (pwr_mode)
			CPR_PWR_DOWN: pwr_down_d = 1'b1;
			CPR_PWR_STANDBY: standby_d = 1'b1;
			CPR_PWR_RESET: dreset_d = 1'b1;
			default: dreset_d = 1'b0;
		endcase
		if (active_q.modes[CPR_PIN_EN_BIT] && pin_s2_q) begin
			case (pin_fn)
				CPR_PIN_PWR_DOWN: pwr_down_d = 1'b1;
				CPR_PIN_STANDBY: standby_d = 1'b1;
				CPR_PIN_NORM_OFF: begin
					pwr_down_d = 1'b0;
					standby_d = 1'b0;
					oe_d = 1'b0;
				end
				CPR_PIN_NORM_ON: begin
					pwr_down_d = 1'b0;
					standby_d = 1'b0;
					oe_d = 1'b1;
				end
				default: oe_d = 1'b1;
			endcase
		end
		if (pwr_down_d || standby_d) begin
			oe_d = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pin_s1_q <= 1'b0;
			pin_s2_q <= 1'b0;
			pwr_down_q <= 1'b0;
			standby_q <= 1'b0;
			oe_q <= 1'b0;
			dreset_q <= 1'b0;
		end else begin
			pin_s1_q <= mode_pin;
			pin_s2_q <= pin_s1_q;
			pwr_down_q <= pwr_down_d;
			standby_q <= standby_d;
			oe_q <= oe_d;
			dreset_q <= dreset_d;
		end
	end

	assign power_down = pwr_down_q;
	assign standby = standby_q;
	assign out_enable = oe_q;
	assign digital_reset = dreset_q;
	assign self_test_run = active_q.self_test[CPR_ST_RUN_BIT];
	assign self_test_init = active_q.self_test[CPR_ST_INIT_BIT];

	// ==========================================================
	// input clock divider
	logic [2:0] div_cnt_q, div_cnt_d;
	logic [2:0] div_val;
	logic strobe;

	assign div_val = active_q.clk_div[CPR_DIV_LSB +: 3];
	assign strobe = (div_cnt_q >= div_val);

	always_comb begin
		div_cnt_d = strobe ? 3'h0 : div_cnt_q + 3'h1;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			div_cnt_q <= 3'h0;
		end else begin
			div_cnt_q <= div_cnt_d;
		end
	end

	assign sample_strobe = strobe;

	// ==========================================================
	// offset trim and output select
	logic [3:0] test_code;
	logic [DATA_W-1:0] pattern;
	logic signed [DATA_W:0] sum;
	logic [DATA_W-1:0] trimmed;
	logic [DATA_W-1:0] dout_q, dout_d;

	assign test_code = active_q.test[CPR_TEST_LSB +: 4];

	cpr_pattern_gen #(
		.DATA_W(DATA_W)
	) u_pattern (
		.clk(clk),
		.reset_n(reset_n),
		.advance(strobe),
		.test_code(test_code),
		.reset_long(active_q.test[CPR_RST_LONG_BIT]),
		.reset_short(active_q.test[CPR_RST_SHORT_BIT]),
		.user_pattern(user_pattern),
		.pattern(pattern)
	);

	always_comb begin
		sum = $signed({sample_in[DATA_W-1], sample_in})
			+ $signed({{(DATA_W-7){active_q.offset[7]}}, active_q.offset});
		if (sum[DATA_W] != sum[DATA_W-1]) begin
			trimmed = sum[DATA_W] ? {1'b1, {(DATA_W-1){1'b0}}} : {1'b0, {(DATA_W-1){1'b1}}};
		end else begin
			trimmed = sum[DATA_W-1:0];
		end
		dout_d = dout_q;
		if (strobe) begin
			dout_d = (test_code != CPR_TP_OFF) ? pattern : trimmed;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			dout_q <= '0;
		end else begin
			dout_q <= dout_d;
		end
	end

	assign data_out = dout_q;

endmodule

// file: tb/cpr_top_properties.sv
/*
 * port checker of cpr_top.
 * assumes a bind onto cpr_top, one clock, async active-low reset.
 */
`timescale 1ns/1ps
module cpr_top_properties #(
	parameter int DATA_W = cpr_pkg::CPR_DATA_W
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire cpr_pkg::cpr_req_s reg_req,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid,
	input wire logic mode_pin,
	input wire logic [DATA_W-1:0] sample_in,
	input wire logic [DATA_W-1:0] user_pattern,
	input wire logic [DATA_W-1:0] data_out,
	input wire logic sample_strobe,
	input wire logic out_enable,
	input wire logic power_down,
	input wire logic standby,
	input wire logic digital_reset,
	input wire logic self_test_run,
	input wire logic self_test_init
);
	import cpr_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	// ==========================================================
	// register port
	a_read_answer: assert property (reg_req.rd_en |=> reg_rvalid)
		else $error("read not answered");
	a_rvalid_cause: assert property (reg_rvalid |-> $past(reg_req.rd_en))
		else $error("answer without read");
	a_unmapped_read: assert property (reg_req.rd_en && reg_req.addr == 8'h13 |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_commit_clear: assert property ((reg_req.wr_en && reg_req.addr == 8'hFF && reg_req.wdata[0]) ##1
		!reg_req.wr_en ##1 (reg_req.rd_en && reg_req.addr == 8'hFF) |=> reg_rdata == 8'h00)
		else $error("commit bit stuck");

	// ==========================================================
	// outputs
	a_data_hold: assert property (!sample_strobe |=> $stable(data_out))
		else $error("data changed off strobe");
	a_pd_no_oe: assert property (power_down |-> !out_enable)
		else $error("outputs on in power-down");
	a_standby_no_oe: assert property (standby |-> !out_enable)
		else $error("outputs on in standby");
	a_selftest_commit: assert property ($changed({self_test_run, self_test_init}) |->
		$past(reg_req.wr_en && reg_req.addr == 8'hFF && reg_req.wdata[0], 2))
		else $error("self-test changed without commit");
endmodule

bind cpr_top cpr_top_properties #(.DATA_W(DATA_W)) cpr_top_properties_inst (.clk(clk),
	.reset_n(reset_n), .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
	.mode_pin(mode_pin), .sample_in(sample_in), .user_pattern(user_pattern),
	.data_out(data_out), .sample_strobe(sample_strobe), .out_enable(out_enable),
	.power_down(power_down), .standby(standby), .digital_reset(digital_reset),
	.self_test_run(self_test_run), .self_test_init(self_test_init));

// file: tb/cpr_host_model.sv
/*
 * host controller model: byte writes, reads and the commit command.
 * assumes the decoded register port of cpr_top on the same clock.
 */
`timescale 1ns/1ps
module cpr_host_model (
	input wire logic clk,
	output cpr_pkg::cpr_req_s reg_req,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid
);
	import cpr_pkg::*;
	initial reg_req = '0;

	// ==========================================================
	// accesses; idle lines show the inverse of the last value
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_req <= '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: d};
		@(posedge clk);
		reg_req <= '{wr_en: 1'b0, rd_en: 1'b0, addr: ~a, wdata: ~d};
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
		@(posedge clk);
		reg_req.rd_en <= 1'b1;
		reg_req.addr <= a;
		@(posedge clk);
		reg_req.rd_en <= 1'b0;
		reg_req.addr <= ~a;
		#1;
		ok = reg_rvalid;
		d = reg_rdata;
	endtask

	task automatic cm();
		wr(CPR_ADDR_COMMIT, 8'h01);
	endtask
endmodule

// file: tb/cpr_top_bench.sv
/*
 * self-checking bench of cpr_top through its register port.
 * assumes the host model, the checker bind and the shared package.
 */
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin n_fail++; \
	$display("unexpected %s: expected %h seen %h", nm, exp, got); end end
module cpr_top_bench;
	import cpr_pkg::*;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic mode_pin = 1'b0;
	logic [13:0] sample_in = 14'h0000;
	logic [13:0] user_pattern = 14'h1234;
	cpr_req_s reg_req;
	logic [7:0] reg_rdata, rv;
	logic reg_rvalid, ok, sample_strobe, out_enable, power_down, standby, st_run, st_init;
	logic dig_rst;
	logic [13:0] data_out, a, b;
	int n_fail = 0;
	int total_checks = 0;
	int cyc = 0;
	int cnt;
	logic [7:0] ra [7] = '{8'h08, 8'h0B, 8'h0D, 8'h0E, 8'h10, 8'h13, 8'hFF};
	logic [7:0] tc [6] = '{8'h01, 8'h02, 8'h03, 8'h08, 8'h0A, 8'h0B};
	logic [13:0] tw [6] = '{14'h0000, 14'h1FFF, 14'h2000, 14'h1234, 14'h3F80, 14'h0001};
	logic [7:0] om [4] = '{8'h80, 8'h01, 8'h80, 8'h7F};
	logic [13:0] os [4] = '{14'h0005, 14'h1FFF, 14'h2000, 14'h0000};
	logic [13:0] oe [4] = '{14'h3F85, 14'h1FFF, 14'h2000, 14'h007F};
	logic [7:0] mm [7] = '{8'h80, 8'hA0, 8'hC0, 8'hE0, 8'h00, 8'h01, 8'h02};
	logic [3:0] mx [7] = '{4'hC, 4'hA, 4'h8, 4'h9, 4'h9, 4'h4, 4'h2};

	always #4 clk = ~clk;

	cpr_host_model h (.clk(clk), .reg_req(reg_req), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid));
	cpr_top #(.DATA_W(14)) cpr_top_inst (.clk(clk), .reset_n(reset_n), .reg_req(reg_req),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .mode_pin(mode_pin),
		.sample_in(sample_in), .user_pattern(user_pattern), .data_out(data_out),
		.sample_strobe(sample_strobe), .out_enable(out_enable), .power_down(power_down),
		.standby(standby), .digital_reset(dig_rst), .self_test_run(st_run),
		.self_test_init(st_init));

	// ==========================================================
	// helpers
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic rchk(input logic [7:0] ad, input logic [7:0] ex);
		h.rd(ad, rv, ok);
		`CHK("rvalid", 1'b1, ok)
		`CHK("rdata", ex, rv)
	endtask

	task automatic sc(input logic [7:0] ad, input logic [7:0] d);
		h.wr(ad, d);
		h.cm();
		repeat (6) @(posedge clk);
		@(negedge clk);
	endtask

	task automatic pair();
		@(negedge clk) a = data_out;
		@(negedge clk) b = data_out;
	endtask

	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			close_out();
		end
	end

	// ==========================================================
	// tests
	initial begin
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		foreach (ra[i]) rchk(ra[i], 8'h00);
		h.wr(8'h08, 8'hE3);
		h.wr(8'h0B, 8'h07);
		h.wr(8'h0E, 8'h05);
		rchk(8'h08, 8'hE3);
		rchk(8'h0B, 8'h07);
		rchk(8'h0E, 8'h05);
		h.wr(8'h08, 8'h00);
		h.wr(8'h0B, 8'h00);
		h.wr(8'h0E, 8'h00);
		@(posedge clk) sample_in <= 14'h0123;
		h.wr(8'h0D, 8'h02);
		repeat (6) @(negedge clk);
		`CHK("shadow data", 14'h0123, data_out)
		h.cm();
		rchk(8'hFF, 8'h00);
		repeat (6) @(negedge clk);
		`CHK("commit data", 14'h1FFF, data_out)
		foreach (tc[i]) begin
			sc(8'h0D, tc[i]);
			`CHK("test word", tw[i], data_out)
		end
		sc(8'h0D, 8'h04);
		pair();
		`CHK("checker", 14'h3FFF, a ^ b)
		`CHK("checker word", 1'b1, a == 14'h2AAA || a == 14'h1555)
		sc(8'h0D, 8'h07);
		pair();
		`CHK("word toggle", 14'h3FFF, a ^ b)
		sc(8'h0D, 8'h09);
		pair();
		`CHK("bit toggle", 1'b1, a[0] ^ b[0])
		sc(8'h0D, 8'h0C);
		pair();
		`CHK("mixed step", 4'h1, 4'(b[3:0] - a[3:0]))
		`CHK("mixed repeat", a[3:0], a[7:4])
		sc(8'h0D, 8'h05);
		pair();
		`CHK("long sequence", 1'b1, a !== b)
		sc(8'h0D, 8'h06);
		pair();
		`CHK("short sequence", 1'b1, a !== b)
		sc(8'h0D, 8'h00);
		foreach (om[i]) begin
			@(posedge clk) sample_in <= os[i];
			sc(8'h10, om[i]);
			`CHK("trim", oe[i], data_out)
		end
		for (int d = 3; d >= 0; d -= 2) begin
			sc(8'h0B, 8'(d));
			cnt = 0;
			repeat (16) @(negedge clk) cnt += int'(sample_strobe);
			`CHK("strobes", 16 / (d + 1), cnt)
		end
		sc(8'h0B, 8'h00);
		foreach (mm[i]) begin
			@(posedge clk) mode_pin <= mx[i][3];
			sc(8'h08, mm[i]);
			`CHK("pins", mx[i][2:0], {power_down, standby, out_enable})
		end
		sc(8'h08, 8'h03);
		`CHK("digital reset", 1'b1, dig_rst)
		sc(8'h08, 8'h00);
		`CHK("digital reset off", 1'b0, dig_rst)
		h.wr(8'h0E, 8'h05);
		repeat (4) @(negedge clk);
		`CHK("self-test shadow", 1'b0, st_run)
		h.cm();
		repeat (4) @(negedge clk);
		`CHK("self-test run", 1'b1, st_run)
		`CHK("self-test init", 1'b1, st_init)
		close_out();
	end
endmodule
